// file: pkg/sws_pkg.sv
// Purpose : constants and helpers for the stop hit wave selection block
// Assumes : one 16-bit configuration word, 6-bit wave fields
// Notes   : the clamp helper is shared by both hit selections

package sws_pkg;

    // ------------------------------------------------------------
    // configuration word layout
    // ------------------------------------------------------------
    localparam int          CFG_W         = 16;
    localparam int          WAVE_W        = 6;
    localparam int          HIT1_LSB      = 8;
    localparam int          HIT2_LSB      = 0;
    localparam logic [15:0] CFG_RESET     = 16'h0000;
    localparam logic [15:0] CFG_WRITE_MSK = 16'h3F3F;

    // ------------------------------------------------------------
    // wave limits
    // ------------------------------------------------------------
    localparam logic [5:0]  HIT1_MIN_WAVE = 6'h03;
    localparam logic [5:0]  HIT2_MIN_WAVE = 6'h04;
    localparam logic [5:0]  WAVE_MAX      = 6'h3F;
    localparam logic [5:0]  WAVE_ZERO     = 6'h00;

    // ------------------------------------------------------------
    // capture timing
    // ------------------------------------------------------------
    localparam int          TIME_W        = 16;

    typedef enum logic [2:0] {
        SWS_IDLE  = 3'h1,
        SWS_COUNT = 3'h2,
        SWS_DONE  = 3'h4
    } sws_state_t;

    // selections below the minimum wave map to the minimum wave
    function automatic logic [5:0] clamp_wave(input logic [5:0] sel,
                                              input logic [5:0] min_wave);
        clamp_wave = (sel < min_wave) ? min_wave : sel;
    endfunction : clamp_wave

endpackage : sws_pkg

// file: core/sws_hit_capture.sv
// Purpose : captures the stop time of one selected received wave
// Assumes : edge_wave is the number of the wave whose edge is seen now
// Notes   : holds the time until the next clear

`timescale 1ns/1ps
`default_nettype none

module sws_hit_capture (
    // clock and reset
    input  wire logic                        clk,
    input  wire logic                        srst,
    // control
    input  wire logic                        clear,
    input  wire logic                        wave_edge,
    input  wire logic [sws_pkg::WAVE_W-1:0]  edge_wave,
    input  wire logic [sws_pkg::WAVE_W-1:0]  sel_wave,
    input  wire logic [sws_pkg::TIME_W-1:0]  time_now,
    // result
    output logic      [sws_pkg::TIME_W-1:0]  hit_time,
    output logic                             hit_valid
);

    typedef struct packed {
        logic [sws_pkg::TIME_W-1:0] tstamp;
        logic                       valid;
    } sws_cap_t;

    sws_cap_t cur;
    sws_cap_t next_cur;

    // ------------------------------------------------------------
    // capture on the selected wave
    // ------------------------------------------------------------
    always_comb begin
        next_cur = cur;
        if (clear) begin
            next_cur.valid  = 1'b0;
            next_cur.tstamp = '0;
        end else if (wave_edge && !cur.valid && edge_wave == sel_wave) begin
            next_cur.valid  = 1'b1;
            next_cur.tstamp = time_now;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            cur <= '0;
        end else begin
            cur <= next_cur;
        end
    end

    assign hit_time  = cur.tstamp;
    assign hit_valid = cur.valid;

endmodule : sws_hit_capture

`default_nettype wire

// file: core/sws_stop_hit_wave_select.sv
// Purpose : holds the first/second stop wave selection word and times
//           the selected received waves as stop hits one and two
// Assumes : wave edges and time base come from logic on REF_CLK
// Notes   : the host keeps the selections increasing

`timescale 1ns/1ps
`default_nettype none

module sws_stop_hit_wave_select (
    // clock and reset
    input  wire logic                        REF_CLK,
    input  wire logic                        SRST,
    // configuration access
    input  wire logic                        CFG_WR,
    input  wire logic [sws_pkg::CFG_W-1:0]   CFG_WDATA,
    output logic      [sws_pkg::CFG_W-1:0]   CFG_RDATA,
    // measurement path
    input  wire logic                        MEAS_START,
    input  wire logic                        WAVE_EDGE,
    input  wire logic [sws_pkg::TIME_W-1:0]  TIME_NOW,
    // effective selections
    output logic      [sws_pkg::WAVE_W-1:0]  FIRST_WAVE,
    output logic      [sws_pkg::WAVE_W-1:0]  SECOND_WAVE,
    // results
    output logic      [sws_pkg::TIME_W-1:0]  HIT1_TIME,
    output logic                             HIT1_VALID,
    output logic      [sws_pkg::TIME_W-1:0]  HIT2_TIME,
    output logic                             HIT2_VALID,
    output logic                             MEAS_DONE,
    output logic      [sws_pkg::WAVE_W-1:0]  WAVE_COUNT
);

    typedef struct packed {
        logic [sws_pkg::CFG_W-1:0]  cfg;
        logic [sws_pkg::WAVE_W-1:0] first_wave;
        logic [sws_pkg::WAVE_W-1:0] second_wave;
        logic [sws_pkg::WAVE_W-1:0] wave_cnt;
        sws_pkg::sws_state_t        state;
    } sws_top_t;

    sws_top_t                   cur;
    sws_top_t                   next_cur;
    logic [sws_pkg::WAVE_W-1:0] edge_wave;
    logic                       counting;
    logic                       clear_hits;
    logic                       hit1_valid;
    logic                       hit2_valid;
    logic [sws_pkg::TIME_W-1:0] hit1_time;
    logic [sws_pkg::TIME_W-1:0] hit2_time;

    // ------------------------------------------------------------
    // wave numbering and control
    // ------------------------------------------------------------
    assign counting   = (cur.state == sws_pkg::SWS_COUNT);
    assign clear_hits = MEAS_START;
    assign edge_wave  = (cur.wave_cnt == sws_pkg::WAVE_MAX) ?
                        sws_pkg::WAVE_MAX : cur.wave_cnt + 6'h01;

    always_comb begin
        next_cur = cur;
        // reserved bits never stored
        if (CFG_WR) begin
            next_cur.cfg = CFG_WDATA & sws_pkg::CFG_WRITE_MSK;
        end
        next_cur.first_wave = sws_pkg::clamp_wave(
            next_cur.cfg[sws_pkg::HIT1_LSB +: sws_pkg::WAVE_W],
            sws_pkg::HIT1_MIN_WAVE);
        next_cur.second_wave = sws_pkg::clamp_wave(
            next_cur.cfg[sws_pkg::HIT2_LSB +: sws_pkg::WAVE_W],
            sws_pkg::HIT2_MIN_WAVE);
        case (cur.state)
            sws_pkg::SWS_IDLE: begin
                if (MEAS_START) begin
                    next_cur.state    = sws_pkg::SWS_COUNT;
                    next_cur.wave_cnt = sws_pkg::WAVE_ZERO;
                end
            end
            sws_pkg::SWS_COUNT: begin
                if (MEAS_START) begin
                    next_cur.wave_cnt = sws_pkg::WAVE_ZERO;
                end else begin
                    if (WAVE_EDGE) begin
                        next_cur.wave_cnt = edge_wave;
                    end
                    if (hit1_valid && hit2_valid) begin
                        next_cur.state = sws_pkg::SWS_DONE;
                    end
                end
            end
            sws_pkg::SWS_DONE: begin
                if (MEAS_START) begin
                    next_cur.state    = sws_pkg::SWS_COUNT;
                    next_cur.wave_cnt = sws_pkg::WAVE_ZERO;
                end
            end
            default: begin
                next_cur.state = sws_pkg::SWS_IDLE;
            end
        endcase
    end

    always_ff @(posedge REF_CLK) begin
        if (SRST) begin
            cur.cfg         <= sws_pkg::CFG_RESET;
            cur.first_wave  <= sws_pkg::HIT1_MIN_WAVE;
            cur.second_wave <= sws_pkg::HIT2_MIN_WAVE;
            cur.wave_cnt    <= sws_pkg::WAVE_ZERO;
            cur.state       <= sws_pkg::SWS_IDLE;
        end else begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // stop hit capture units
    // ------------------------------------------------------------
    sws_hit_capture u_hit1 (
        .clk       (REF_CLK),
        .srst      (SRST),
        .clear     (clear_hits),
        .wave_edge (WAVE_EDGE & counting),
        .edge_wave (edge_wave),
        .sel_wave  (cur.first_wave),
        .time_now  (TIME_NOW),
        .hit_time  (hit1_time),
        .hit_valid (hit1_valid)
    );

    sws_hit_capture u_hit2 (
        .clk       (REF_CLK),
        .srst      (SRST),
        .clear     (clear_hits),
        .wave_edge (WAVE_EDGE & counting),
        .edge_wave (edge_wave),
        .sel_wave  (cur.second_wave),
        .time_now  (TIME_NOW),
        .hit_time  (hit2_time),
        .hit_valid (hit2_valid)
    );

    // ------------------------------------------------------------
    // outputs
    // ------------------------------------------------------------
    assign CFG_RDATA   = cur.cfg;
    assign FIRST_WAVE  = cur.first_wave;
    assign SECOND_WAVE = cur.second_wave;
    assign HIT1_TIME   = hit1_time;
    assign HIT1_VALID  = hit1_valid;
    assign HIT2_TIME   = hit2_time;
    assign HIT2_VALID  = hit2_valid;
    assign MEAS_DONE   = (cur.state == sws_pkg::SWS_DONE);
    assign WAVE_COUNT  = cur.wave_cnt;

endmodule : sws_stop_hit_wave_select

`default_nettype wire

// file: verif/sws_stop_hit_wave_select_checker.sv
// Purpose : port-level assertions for the stop hit wave selection block
// Assumes : one clock domain, synchronous active-high reset
// Notes   : bound to every instance of the top module
`timescale 1ns/1ps
`default_nettype none
module sws_stop_hit_wave_select_checker (
    // clock and reset
    input wire logic        REF_CLK,
    input wire logic        SRST,
    // watched ports
    input wire logic        CFG_WR,
    input wire logic [15:0] CFG_WDATA,
    input wire logic [15:0] CFG_RDATA,
    input wire logic        WAVE_EDGE,
    input wire logic [5:0]  FIRST_WAVE,
    input wire logic [5:0]  SECOND_WAVE,
    input wire logic        HIT1_VALID,
    input wire logic        HIT2_VALID,
    input wire logic [5:0]  WAVE_COUNT
);
    default clocking @(posedge REF_CLK); endclocking
    default disable iff (SRST);
    AST_FIRST_FIELD: assert property (CFG_WR |=> FIRST_WAVE == (($past(CFG_WDATA[13:8]) < 6'h03) ? 6'h03 : $past(CFG_WDATA[13:8]))) else $error("first wave bad");
    AST_SECOND_FIELD: assert property (CFG_WR |=> SECOND_WAVE == (($past(CFG_WDATA[5:0]) < 6'h04) ? 6'h04 : $past(CFG_WDATA[5:0]))) else $error("second wave bad");
    AST_RSVD_DROP: assert property (CFG_WR |=> CFG_RDATA == ($past(CFG_WDATA) & 16'h3F3F)) else $error("reserved bits kept");
    AST_CFG_HOLD: assert property (!CFG_WR |=> $stable(CFG_RDATA) && $stable(FIRST_WAVE)) else $error("config changed");
    AST_FIRST_MIN: assert property (FIRST_WAVE >= 6'h03) else $error("first below 3");
    AST_SECOND_MIN: assert property (SECOND_WAVE >= 6'h04) else $error("second below 4");
    AST_HIT1_WAVE: assert property ($rose(HIT1_VALID) |-> $past(WAVE_EDGE) && 6'($past(WAVE_COUNT) + 6'h01) == $past(FIRST_WAVE)) else $error("hit1 wrong wave");
    AST_HIT2_WAVE: assert property ($rose(HIT2_VALID) |-> $past(WAVE_EDGE) && 6'($past(WAVE_COUNT) + 6'h01) == $past(SECOND_WAVE)) else $error("hit2 wrong wave");
    COV_CLAMP: cover property (CFG_WR && CFG_WDATA[13:8] < 6'h03);
    COV_HIT1: cover property ($rose(HIT1_VALID));
    COV_HIT2: cover property ($rose(HIT2_VALID));
endmodule : sws_stop_hit_wave_select_checker
bind sws_stop_hit_wave_select sws_stop_hit_wave_select_checker u_chk (.REF_CLK(REF_CLK),
    .SRST(SRST), .CFG_WR(CFG_WR), .CFG_WDATA(CFG_WDATA), .CFG_RDATA(CFG_RDATA),
    .WAVE_EDGE(WAVE_EDGE), .FIRST_WAVE(FIRST_WAVE), .SECOND_WAVE(SECOND_WAVE),
    .HIT1_VALID(HIT1_VALID), .HIT2_VALID(HIT2_VALID), .WAVE_COUNT(WAVE_COUNT));
`default_nettype wire

// file: verif/sws_host_model.sv
// Purpose : host writing the selection word
// Assumes : one-cycle write strobe
// Notes   : lax mode sends the word as given
`timescale 1ns/1ps
`default_nettype none
module sws_host_model #(
    // threshold wave set in the other register; default is arbitrary
    parameter logic [5:0] second_threshold_wave = 6'h04
) (
    // clock
    input wire logic         clk,
    // write port
    output var logic         cfg_wr,
    output var logic [15:0]  cfg_wdata
);
    initial begin
        cfg_wr    = 1'b0;
        cfg_wdata = 16'hA5A5;
    end
    task automatic write(input logic [15:0] w, input logic lax, output logic [15:0] sent);
        logic [5:0] f;
        if (!lax && w[13:8] <= second_threshold_wave) begin
            w[13:8] = 6'(second_threshold_wave + 6'h01);
        end
        f = (w[13:8] < 6'h03) ? 6'h03 : w[13:8];
        if (!lax && w[5:0] <= f) w[5:0] = f + 6'h01;
        sent = w;
        @(posedge clk);
        #1 cfg_wr = 1'b1;
        cfg_wdata = w;
        @(posedge clk);
        #1 cfg_wr = 1'b0;
        cfg_wdata = ~w;
    endtask : write
endmodule : sws_host_model
`default_nettype wire

// file: verif/sws_stop_hit_wave_select_bench.sv
// Purpose : self-checking bench for the stop hit wave selection block
// Assumes : results are compared by a monitor against queued notes
// Notes   : host model issues all configuration writes
`timescale 1ns/1ps
`default_nettype none
`define CHK(n, e, a) begin checks_done++; if ((a) !== (e)) begin n_errors++; \
    $display("BAD %s exp %h got %h", n, e, a); end end
module sws_stop_hit_wave_select_bench;
    logic ref_clk = 0, srst = 1, meas_start = 0, wave_edge = 0, cfg_wr, wr_d = 0, dn_d = 0;
    logic [15:0] time_now = 0, cfg_wdata, cfg_rdata, h1t, h2t;
    logic [5:0] first_wave, second_wave, wave_count;
    logic h1v, h2v, meas_done;
    logic [31:0] rs = 32'hE1E6, t;
    logic [27:0] qc[$], ec;
    logic [31:0] qh[$], eh;
    logic [15:0] sent_w;
    int n_errors = 0, checks_done = 0, cyc = 0;
    always #4 ref_clk = ~ref_clk;
    sws_host_model u_host (.clk(ref_clk), .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));
    sws_stop_hit_wave_select DUT (.REF_CLK(ref_clk), .SRST(srst), .CFG_WR(cfg_wr),
        .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .MEAS_START(meas_start),
        .WAVE_EDGE(wave_edge), .TIME_NOW(time_now), .FIRST_WAVE(first_wave),
        .SECOND_WAVE(second_wave), .HIT1_TIME(h1t), .HIT1_VALID(h1v), .HIT2_TIME(h2t),
        .HIT2_VALID(h2v), .MEAS_DONE(meas_done), .WAVE_COUNT(wave_count));
    function automatic logic [31:0] xs();
        rs ^= rs << 13;
        rs ^= rs >> 17;
        rs ^= rs << 5;
        return rs;
    endfunction : xs
    function automatic logic [5:0] lo(input logic [5:0] v, input logic [5:0] m);
        return (v < m) ? m : v;
    endfunction : lo
    task automatic wr(input logic [15:0] w, input logic lax);
        u_host.write(w, lax, sent_w);
        qc.push_back({sent_w & 16'h3F3F, lo(sent_w[13:8], 6'h03), lo(sent_w[5:0], 6'h04)});
    endtask : wr
    task automatic meas(input logic [5:0] f, input logic [5:0] s);
        logic [15:0] t1, t2;
        logic [5:0]  fe, se;
        int k;
        wr({2'b00, f, 2'b00, s}, 1'b0);
        fe = lo(sent_w[13:8], 6'h03);
        se = lo(sent_w[5:0], 6'h04);
        meas_start = 1;
        @(posedge ref_clk);
        #1 meas_start = 0;
        k = 0;
        while (k < se) begin
            t = xs();
            wave_edge = t[0] | t[1];
            time_now = t[31:16];
            if (wave_edge) k++;
            if (wave_edge && k == fe) t1 = time_now;
            if (wave_edge && k == se) t2 = time_now;
            @(posedge ref_clk);
            #1;
        end
        wave_edge = 0;
        qh.push_back({t1, t2});
        `CHK("count", se, wave_count)
        repeat (4) @(posedge ref_clk);
    endtask : meas
    always @(posedge ref_clk) begin
        if (wr_d && qc.size() > 0) begin
            ec = qc.pop_front();
            `CHK("config", ec, {cfg_rdata, first_wave, second_wave})
        end
        if (meas_done && !dn_d && qh.size() > 0) begin
            eh = qh.pop_front();
            `CHK("hits", eh, {h1t, h2t})
        end
        wr_d = cfg_wr;
        dn_d = meas_done;
        if (++cyc == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end
    task automatic tally_and_finish();
        `CHK("pending", 32'h0, 32'(qh.size() + qc.size()))
        $display("checks %0d errors %0d", checks_done, n_errors);
        if (n_errors == 0 && checks_done > 0) $display("No errors found");
        else $display("Errors were found");
        $finish;
    endtask : tally_and_finish
    initial begin
        repeat (4) @(posedge ref_clk);
        #1 srst = 0;
        `CHK("reset", 28'h00000C4, {cfg_rdata, first_wave, second_wave})
        for (int i = 0; i < 8; i++) wr({2'b11, 6'(i), 2'b11, 6'(i)}, 1'b1);
        wr(16'hFFFF, 1'b1);
        repeat (20) wr(16'(xs()), 1'b1);
        meas(6'h00, 6'h00);
        meas(6'h05, 6'h09);
        repeat (4) begin
            t = xs();
            meas(6'h03 + 6'(t[4:0]), 6'h24 + 6'(t[10:8]));
        end
        tally_and_finish();
    end
endmodule : sws_stop_hit_wave_select_bench
`default_nettype wire
